/* File: rtl/emb_bus_ctrl.sv */
// Summary of operation
// - 24-bit internal address, narrower external bus
// - Map 00: eighteen bits, A16/A17 on shared pins
// - Map 01: seventeen bits, A17 pin freed
// - Map 01: program and write strobes everywhere
// - Map 10: sixteen bits, both shared pins freed
// - Map 11: code regions program strobe, data data-strobe
// - Map 11: writes only to regions 00/01
// - Each wait adds two oscillator periods
// - General wait field for non-01 regions
// - Region-one field sets waits for region 01
// - Legacy bit may add one region-01 wait
// - Long-latch bit cleared: three-period latch pulse
// - On-chip code window served internally
// - Legacy bit cleared adds one, set none
// - Map 11 strobe chosen by address bit 23
// - Maps 00-10: all reads program strobe, all writes
`timescale 1ns/1ps
`default_nettype none
module emb_bus_ctrl
  import emb_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Configuration straps, asynchronous to i_clk
  input wire emb_pkg::emb_cfg_s i_strap,
  // Core request side, same clock
  input wire logic i_req_valid,
  input wire emb_pkg::emb_req_s i_req,
  output logic o_busy,
  output logic o_done,
  output logic o_internal_hit,
  output logic o_write_blocked,
  output logic [7:0] o_rdata,
  // Port values for shared pins when they act as port bits
  input wire logic i_port_a16_value,
  input wire logic i_port_a17_value,
  // External bus pins
  output logic o_ale,
  output logic [7:0] o_addr_hi,
  input wire logic [7:0] i_ext_data,
  output logic [7:0] o_ext_data,
  output logic o_ext_data_oe,
  output logic o_program_read_strobe_n,
  output logic o_write_strobe_n,
  output logic o_shared_read_a16_pin,
  output logic o_shared_a17_pin,
  output logic o_a16_pin_is_port,
  output logic o_a17_pin_is_port,
  // Frozen configuration for the rest of the chip
  output emb_pkg::emb_cfg_s o_cfg
);

  // Sequencer states; the fourth code is unused
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LATCH,
    ST_STROBE
  } emb_state_e;

  // Configuration path and decode result
  emb_cfg_s strap_sync;
  emb_cfg_s cfg;
  emb_cfg_s next_cfg;
  emb_dec_s dec;
  emb_dec_s cur;
  emb_dec_s next_cur;
  emb_req_s req;
  emb_req_s next_req;

  // Sequencer state and cycle counter
  emb_state_e state;
  emb_state_e next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] ale_cyc;
  logic [CNT_W-1:0] strobe_cyc;
  logic take;

  // Next values of the registered outputs
  logic next_busy;
  logic next_done;
  logic next_internal_hit;
  logic next_write_blocked;
  logic [7:0] next_rdata;
  logic next_ale;
  logic [7:0] next_addr_hi;
  logic [7:0] next_ext_data;
  logic next_ext_data_oe;
  logic next_prog_n;
  logic next_write_n;
  logic next_a16_pin;
  logic next_a17_pin;
  logic next_a16_is_port;
  logic next_a17_is_port;

  // Straps come from pins, so they pass the three-stage filter
  // Limitation: straps must be steady five cycles before reset ends
  emb_sync #(
    .W($bits(emb_cfg_s))
  ) u_strap_sync (
    .i_clk(i_clk),
    .i_async(i_strap),
    .o_sync(strap_sync)
  );

  // Decode uses the frozen configuration and the incoming request
  // Its result is kept in cur when the request is taken
  emb_decode u_decode (
    .i_cfg(cfg),
    .i_req(i_req),
    .o_dec(dec)
  );

  // Configuration follows the straps only while reset is held
  always_comb begin
    // Straps that change after reset are ignored until the next reset
    next_cfg = i_rst_b ? cfg : strap_sync;
  end

  // No reset term: capture must run while reset is held
  always_ff @(posedge i_clk) begin
    cfg <= next_cfg;
  end

  // Phase lengths in clock cycles for the latched settings
  // Counts are loaded minus one, so a phase of n cycles ends on zero
  always_comb begin
    ale_cyc = (cfg.long_latch_pulse_n ? ALE_SHORT_OSC : ALE_LONG_OSC) * OSC_CYC;
    strobe_cyc = (STROBE_BASE_OSC + WAIT_OSC * CNT_W'(cur.waits)) * OSC_CYC;
  end

  // Only idle takes a request; a busy core keeps i_req_valid up
  assign take = (state == ST_IDLE) && i_req_valid;

  // Bus cycle sequencer: latch phase, strobe phase, back to idle
  always_comb begin
    // Pulses clear by default; request context holds for the pins
    next_state = state;
    next_cnt = cnt;
    next_req = req;
    next_cur = cur;
    next_done = 1'b0;
    next_internal_hit = 1'b0;
    next_write_blocked = 1'b0;
    next_rdata = o_rdata;
    // Back to back: idle in the done cycle, so the next take follows at once
    unique case (state)
      ST_IDLE: begin
        if (take) begin
          // Request and its decode are captured together
          next_req = i_req;
          next_cur = dec;
          if (dec.internal) begin
            // On-chip code: no external cycle at all
            next_internal_hit = 1'b1;
            next_done = 1'b1;
          end else begin
            // External cycle opens with the address latch phase
            next_state = ST_LATCH;
            next_cnt = ale_cyc - 6'h01;
          end
        end
      end
      ST_LATCH: begin
        // Hold the latch pulse for its configured length
        if (cnt == '0) begin
          next_state = ST_STROBE;
          next_cnt = strobe_cyc - 6'h01;
        end else begin
          next_cnt = cnt - 6'h01;
        end
      end
      ST_STROBE: begin
        if (cnt == '0) begin
          next_state = ST_IDLE;
          next_done = 1'b1;
          // Write outside the data regions runs the cycle but stays silent
          next_write_blocked = req.write && !cur.write_ok;
          // Read data taken on the last strobe cycle, strobe still low
          if (!req.write) begin
            next_rdata = i_ext_data;
          end
        end else begin
          next_cnt = cnt - 6'h01;
        end
      end
      default: begin
        // Unused state code: fall back to idle rather than hang
        next_state = ST_IDLE;
      end
    endcase
  end

  // Pin levels for the cycle that the next state describes
  always_comb begin
    // Defaults: strobes off, bus released, shared pins hold
    next_busy = (next_state != ST_IDLE);
    next_ale = (next_state == ST_LATCH);
    next_addr_hi = o_addr_hi;
    next_ext_data = o_ext_data;
    next_ext_data_oe = 1'b0;
    next_prog_n = 1'b1;
    next_write_n = 1'b1;
    next_a16_pin = o_shared_read_a16_pin;
    // Pin roles follow the frozen map only
    next_a16_is_port = (cfg.strobe_map_select == MAP_16BIT);
    next_a17_is_port = (cfg.strobe_map_select != MAP_18BIT);
    // High address byte stays on its pins between cycles
    if (next_state != ST_IDLE) begin
      next_addr_hi = next_req.addr[15:8];
    end
    if (next_state == ST_LATCH) begin
      // Low address multiplexed on the data port while the latch pulse is high
      next_ext_data = next_req.addr[7:0];
      next_ext_data_oe = 1'b1;
    end else if (next_state == ST_STROBE) begin
      if (next_req.write) begin
        next_ext_data = next_req.wdata;
        next_ext_data_oe = 1'b1;
        next_write_n = !next_cur.write_ok;
      end else begin
        next_prog_n = !next_cur.prog_read;
      end
    end
    // Shared read/A16 pin role
    unique case (cfg.strobe_map_select)
      MAP_18BIT, MAP_17BIT: begin
        // Address bit 16, held between cycles
        next_a16_pin = (next_state != ST_IDLE) ? next_cur.a16 : o_shared_read_a16_pin;
      end
      MAP_16BIT: begin
        // Plain port bit, no bus role
        next_a16_pin = i_port_a16_value;
      end
      MAP_SPLIT: begin
        // Data-read strobe, active low
        next_a16_pin = !((next_state == ST_STROBE) && !next_req.write &&
                         next_cur.data_read);
      end
    endcase
    // Shared A17 pin carries address only for the widest map
    if (cfg.strobe_map_select == MAP_18BIT) begin
      next_a17_pin = (next_state != ST_IDLE) ? next_cur.a17 : o_shared_a17_pin;
    end else begin
      next_a17_pin = i_port_a17_value;
    end
  end

  // Sequencer and pin registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      // Strobes idle high and the bus released while reset is held
      state <= ST_IDLE;
      cnt <= '0;
      req <= '0;
      cur <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_internal_hit <= 1'b0;
      o_write_blocked <= 1'b0;
      o_rdata <= 8'h00;
      o_ale <= 1'b0;
      o_addr_hi <= 8'h00;
      o_ext_data <= 8'h00;
      o_ext_data_oe <= 1'b0;
      o_program_read_strobe_n <= 1'b1;
      o_write_strobe_n <= 1'b1;
      o_shared_read_a16_pin <= 1'b1;
      o_shared_a17_pin <= 1'b0;
      o_a16_pin_is_port <= 1'b0;
      o_a17_pin_is_port <= 1'b0;
      o_cfg <= CFG_RESET;
    end else begin
      // Every output straight from a register
      state <= next_state;
      cnt <= next_cnt;
      req <= next_req;
      cur <= next_cur;
      o_busy <= next_busy;
      o_done <= next_done;
      o_internal_hit <= next_internal_hit;
      o_write_blocked <= next_write_blocked;
      o_rdata <= next_rdata;
      o_ale <= next_ale;
      o_addr_hi <= next_addr_hi;
      o_ext_data <= next_ext_data;
      o_ext_data_oe <= next_ext_data_oe;
      o_program_read_strobe_n <= next_prog_n;
      o_write_strobe_n <= next_write_n;
      o_shared_read_a16_pin <= next_a16_pin;
      o_shared_a17_pin <= next_a17_pin;
      o_a16_pin_is_port <= next_a16_is_port;
      o_a17_pin_is_port <= next_a17_is_port;
      o_cfg <= cfg;
    end
  end

endmodule : emb_bus_ctrl
`default_nettype wire

/* File: rtl/emb_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module emb_decode (
  input wire emb_pkg::emb_cfg_s i_cfg,
  input wire emb_pkg::emb_req_s i_req,
  output emb_pkg::emb_dec_s o_dec
);
  import emb_pkg::*;

  logic [7:0] region;
  logic is_region_one;

  assign region = i_req.addr[ADDR_W-1:REGION_LSB];
  assign is_region_one = (region == REGION_ONE);

  // Region, strobe and wait decode for one request
  always_comb begin
    o_dec = '0;
    // On-chip code window when external code is not forced
    o_dec.internal = i_cfg.external_code_select_n && (region == REGION_CODE_TOP) &&
                     (i_req.addr[15:0] < ONCHIP_CODE_LIMIT);
    if (i_cfg.strobe_map_select == MAP_SPLIT) begin
      // Code space on program strobe, data space on data strobe
      o_dec.prog_read = i_req.addr[CODE_SPACE_BIT];
      o_dec.data_read = !i_req.addr[CODE_SPACE_BIT];
      o_dec.write_ok = (i_req.addr[ADDR_W-1:A17_BIT] == DATA_REGIONS_HI);
    end else begin
      o_dec.prog_read = 1'b1;
      o_dec.data_read = 1'b0;
      o_dec.write_ok = 1'b1;
    end
    // Upper address bits; unused ones alias away
    o_dec.a16 = i_req.addr[A16_BIT];
    o_dec.a17 = i_req.addr[A17_BIT];
    // Field encoding is inverted: 00 gives most waits
    if (is_region_one) begin
      o_dec.waits = MAX_WAITS - {1'b0, i_cfg.region_one_wait_field};
      if (!i_cfg.legacy_region_one_wait) begin
        o_dec.waits = o_dec.waits + LEGACY_WAITS;
      end
    end else begin
      o_dec.waits = MAX_WAITS - {1'b0, i_cfg.general_wait_field};
    end
  end
endmodule : emb_decode
`default_nettype wire

/* File: rtl/emb_pkg.sv */
// Shared constants and carriers for the external memory bus configuration block
package emb_pkg;

  // Address layout
  localparam int ADDR_W = 24;
  localparam int REGION_LSB = 16;
  localparam int CODE_SPACE_BIT = 23;
  localparam int A16_BIT = 16;
  localparam int A17_BIT = 17;
  localparam int CNT_W = 6;

  // Strobe-map select encodings
  localparam logic [1:0] MAP_18BIT = 2'h0;
  localparam logic [1:0] MAP_17BIT = 2'h1;
  localparam logic [1:0] MAP_16BIT = 2'h2;
  localparam logic [1:0] MAP_SPLIT = 2'h3;

  // Regions and on-chip code window
  localparam logic [7:0] REGION_ONE = 8'h01;
  localparam logic [7:0] REGION_CODE_TOP = 8'hff;
  localparam logic [15:0] ONCHIP_CODE_LIMIT = 16'h4000;
  localparam logic [6:0] DATA_REGIONS_HI = 7'h00;

  // Timing: one oscillator period is the unit of bus timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int OSCILLATOR_PERIOD_NS = 20;
  localparam int OSC_CYC_INT = (OSCILLATOR_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] OSC_CYC = CNT_W'(OSC_CYC_INT < 1 ? 1 : OSC_CYC_INT);
  localparam logic [CNT_W-1:0] ALE_SHORT_OSC = 6'h01;
  localparam logic [CNT_W-1:0] ALE_LONG_OSC = 6'h03;
  localparam logic [CNT_W-1:0] STROBE_BASE_OSC = 6'h02;
  localparam logic [CNT_W-1:0] WAIT_OSC = 6'h02;
  localparam logic [2:0] MAX_WAITS = 3'h3;
  localparam logic [2:0] LEGACY_WAITS = 3'h1;

  // Latched configuration
  typedef struct packed {
    logic [1:0] strobe_map_select;
    logic [1:0] general_wait_field;
    logic [1:0] region_one_wait_field;
    logic legacy_region_one_wait;
    logic long_latch_pulse_n;
    logic external_code_select_n;
  } emb_cfg_s;

  // Safest values until straps are seen: widest map, most waits, long latch
  localparam emb_cfg_s CFG_RESET = '{2'h0, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0};

  // One bus request from the core
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic [7:0] wdata;
  } emb_req_s;

  // Decoded handling of a request
  typedef struct packed {
    logic internal;
    logic prog_read;
    logic data_read;
    logic write_ok;
    logic a16;
    logic a17;
    logic [2:0] waits;
  } emb_dec_s;

endpackage : emb_pkg

/* File: rtl/emb_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module emb_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  import emb_pkg::*;

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] next_sync;

  // Accept a change only when the second and third stages agree
  always_comb begin
    next_sync = (stage2 == stage3) ? stage3 : o_sync;
  end

  // No reset: the straps must be sampled while reset is held
  always_ff @(posedge i_clk) begin
    stage1 <= i_async;
    stage2 <= stage1;
    stage3 <= stage2;
    o_sync <= next_sync;
  end
endmodule : emb_sync
`default_nettype wire

/* File: testbench/emb_bus_ctrl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module emb_bus_ctrl_monitor
  import emb_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire emb_cfg_s o_cfg,
  input wire logic o_ale,
  input wire logic o_done,
  input wire logic o_internal_hit,
  input wire logic o_write_blocked,
  input wire logic o_program_read_strobe_n,
  input wire logic o_write_strobe_n,
  input wire logic o_shared_read_a16_pin,
  input wire logic o_a16_pin_is_port,
  input wire logic o_a17_pin_is_port
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  logic stb;
  logic [4:0] stb_len;
  // Any strobe low; in map 11 the data strobe rides the A16 pin
  assign stb = !o_program_read_strobe_n || !o_write_strobe_n ||
    (o_cfg.strobe_map_select == MAP_SPLIT && !o_shared_read_a16_pin);
  // Width of the current strobe, cleared between strobes
  always_ff @(posedge i_clk) begin
    stb_len <= (stb && i_rst_b) ? stb_len + 5'h01 : 5'h00;
  end
  chk_strobe_even: assert property ($fell(stb) |-> !stb_len[0] && stb_len inside {[2:10]})
    else $error("strobe width not two plus two per wait");
  chk_strobe_done: assert property ($fell(stb) |-> o_done)
    else $error("strobe ended without done");
  chk_ale_short: assert property (o_cfg.long_latch_pulse_n && $rose(o_ale) |=> !o_ale)
    else $error("short latch pulse not one cycle");
  chk_ale_long: assert property (!o_cfg.long_latch_pulse_n && $rose(o_ale)
    |-> o_ale [*3] ##1 !o_ale)
    else $error("long latch pulse not three cycles");
  chk_a16_port: assert property ($past(i_rst_b, 2)
    |-> o_a16_pin_is_port == (o_cfg.strobe_map_select == MAP_16BIT))
    else $error("A16 pin port use wrong for map");
  chk_a17_port: assert property ($past(i_rst_b, 2)
    |-> o_a17_pin_is_port == (o_cfg.strobe_map_select != MAP_18BIT))
    else $error("A17 pin port use wrong for map");
  chk_blocked_map: assert property (o_write_blocked |-> o_done && o_cfg.strobe_map_select == MAP_SPLIT)
    else $error("write blocked outside map 11");
  chk_internal_hit: assert property (o_internal_hit |-> o_done && o_cfg.external_code_select_n)
    else $error("internal hit without on-chip code");
  chk_cfg_frozen: assert property ($past(i_rst_b, 2) |-> $stable(o_cfg))
    else $error("configuration moved after reset");
endmodule : emb_bus_ctrl_monitor
bind emb_bus_ctrl emb_bus_ctrl_monitor i_mon (.i_clk, .i_rst_b, .o_cfg, .o_ale, .o_done,
  .o_internal_hit, .o_write_blocked, .o_program_read_strobe_n, .o_write_strobe_n,
  .o_shared_read_a16_pin, .o_a16_pin_is_port, .o_a17_pin_is_port);
`default_nettype wire

/* File: testbench/emb_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model
  import emb_pkg::*;
(
  input wire logic i_clk,
  input wire logic [1:0] i_map,
  input wire logic i_ale,
  input wire logic [7:0] i_hi,
  input wire logic [7:0] i_lo,
  input wire logic i_a16,
  input wire logic i_a17,
  input wire logic i_prog_n,
  input wire logic i_wr_n,
  output logic [7:0] o_data
);
  logic [7:0] mem [0:262143];
  logic [17:0] a = '0;
  logic [7:0] last = 8'h5a;
  logic rd;
  assign rd = !i_prog_n || (i_map == MAP_SPLIT && !i_a16);
  // Unwritten bytes read back as a pattern of their own address
  initial begin
    for (int i = 0; i < 262144; i++) mem[i] = i[7:0] ^ i[15:8];
  end
  // Latch only the lines this map drives, so aliases land together
  always @(posedge i_clk) begin
    if (i_ale) a <= {i_map == MAP_18BIT && i_a17, i_map < MAP_16BIT && i_a16, i_hi, i_lo};
    if (!i_wr_n) mem[a] <= i_lo;
    if (rd) last <= o_data;
  end
  // Released bus shows the inverse, so a stale byte never matches
  always_comb begin
    o_data = ~last;
    if (rd) o_data = mem[a];
  end
endmodule : emb_mem_model
`default_nettype wire

/* File: testbench/tb_emb_bus_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_emb_bus_ctrl
  import emb_pkg::*;
;
  logic i_clk = 0;
  logic i_rst_b = 0;
  logic i_req_valid = 0;
  emb_cfg_s i_strap = '0;
  emb_cfg_s cfg;
  emb_req_s i_req = '0;
  logic p16 = 1'b0;
  logic p17 = 1'b1;
  wire logic busy, done, ih, wb, ale, oe, pn, wn, a16, a17, a16p, a17p;
  wire logic [7:0] rdata, hi, xd, md;
  wire emb_cfg_s o_cfg;
  int n_errors = 0;
  int checks_done = 0;
  emb_bus_ctrl i_dut (.i_clk, .i_rst_b, .i_strap, .i_req_valid, .i_req, .o_busy(busy),
    .o_done(done), .o_internal_hit(ih), .o_write_blocked(wb), .o_rdata(rdata),
    .i_port_a16_value(p16), .i_port_a17_value(p17), .o_ale(ale), .o_addr_hi(hi),
    .i_ext_data(md), .o_ext_data(xd), .o_ext_data_oe(oe), .o_program_read_strobe_n(pn),
    .o_write_strobe_n(wn), .o_shared_read_a16_pin(a16), .o_shared_a17_pin(a17),
    .o_a16_pin_is_port(a16p), .o_a17_pin_is_port(a17p), .o_cfg);
  emb_mem_model i_mem (.i_clk, .i_map(o_cfg.strobe_map_select), .i_ale(ale), .i_hi(hi),
    .i_lo(xd), .i_a16(a16), .i_a17(a17), .i_prog_n(pn), .i_wr_n(wn), .o_data(md));
  initial forever #10 i_clk = ~i_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t got %0h want %0h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    if (n_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // Straps only count during reset; flip them afterwards to prove the freeze
  task automatic do_reset(input emb_cfg_s c);
    @(negedge i_clk);
    i_rst_b = 0;
    i_strap = c;
    cfg = c;
    repeat (6) @(negedge i_clk);
    i_rst_b = 1;
    @(negedge i_clk);
    check(o_cfg, c);
    i_strap = ~c;
  endtask : do_reset
  // One request; checks timing, pins, strobe choice and read data
  task automatic xfer(input logic [23:0] ad, input logic w, input logic [7:0] d);
    int n, cyc;
    logic in, r1, sp, sw, sd, e16;
    r1 = cfg.strobe_map_select == MAP_SPLIT;
    in = cfg.external_code_select_n && ad[23:14] == 10'h3fc;
    cyc = ad[23:16] == 8'h01 ? 3 - cfg.region_one_wait_field + !cfg.legacy_region_one_wait
      : 3 - cfg.general_wait_field;
    cyc = in ? 1 : (cfg.long_latch_pulse_n ? 1 : 3) + 3 + 2 * cyc;
    e16 = cfg.strobe_map_select < MAP_16BIT ? ad[16] : !r1 ? p16 : 1'b1;
    {n, sp, sw, sd} = '0;
    i_req = '{ad, w, d};
    i_req_valid = 1;
    do begin
      @(negedge i_clk);
      n++;
      i_req_valid = 0;
      sp |= !pn;
      sw |= !wn;
      sd |= r1 && !a16;
      if (n == 1) check(busy, !in);
      if (n == 1 && !in) begin
        check({ale, hi, xd, oe}, {1'b1, ad[15:0], 1'b1});
        check({a16, a17}, {e16, cfg.strobe_map_select == MAP_18BIT ? ad[17] : p17});
      end
    end while (!done && n < 40);
    check(n, cyc);
    check(busy, 1'b0);
    check({ih, wb}, {in, w && !in && r1 && ad[23:17] != 7'h00});
    check({sp, sd}, {!w && !in && (!r1 || ad[23]), !w && !in && r1 && !ad[23]});
    check(sw, w && !in && (!r1 || ad[23:17] == 7'h00));
    if (!w && !in) check(rdata, d);
  endtask : xfer
  task automatic s_map00();
    do_reset('{MAP_18BIT, 2'h3, 2'h0, 1'b1, 1'b1, 1'b0});
    xfer(24'h021234, 1, 8'ha5);
    xfer(24'h021234, 0, 8'ha5);
    xfer(24'h011234, 0, 8'h26);
    xfer(24'hff0100, 0, 8'h01);
  endtask : s_map00
  task automatic s_map01();
    do_reset('{MAP_17BIT, 2'h2, 2'h3, 1'b0, 1'b0, 1'b1});
    xfer(24'hff0100, 0, 8'h00);
    xfer(24'h000055, 1, 8'h3c);
    xfer(24'hfe0055, 0, 8'h3c);
    xfer(24'h010100, 0, 8'h01);
  endtask : s_map01
  task automatic s_map10();
    do_reset('{MAP_16BIT, 2'h1, 2'h1, 1'b1, 1'b1, 1'b0});
    p16 = 1'b1;
    xfer(24'h030010, 1, 8'h77);
    xfer(24'h000010, 0, 8'h77);
  endtask : s_map10
  task automatic s_map11();
    do_reset('{MAP_SPLIT, 2'h0, 2'h3, 1'b1, 1'b1, 1'b0});
    p17 = 1'b0;
    xfer(24'hff0020, 0, 8'h20);
    xfer(24'h000021, 0, 8'h21);
    xfer(24'h010030, 1, 8'h99);
    xfer(24'hfe0031, 1, 8'h11);
    xfer(24'hfe0031, 0, 8'h31);
    xfer(24'h010030, 0, 8'h99);
  endtask : s_map11
  // Watchdog far beyond the longest expected run
  initial begin
    repeat (5000) @(posedge i_clk);
    n_errors++;
    print_verdict();
  end
  initial begin
    s_map00();
    s_map01();
    s_map10();
    s_map11();
    print_verdict();
  end
endmodule : tb_emb_bus_ctrl
`default_nettype wire
